// file: verilog/bdmc_pkg.sv
// package of constants for the bus driver mode control block
package bdmc_pkg;
  // clock rate and derived timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TX_ACTIVE_LIMIT_US = 1500; // transmit_active_limit, 1.5 ms
  localparam int unsigned TX_ACTIVE_LIMIT_CYC = TX_ACTIVE_LIMIT_US * (CLK_HZ / 1000000);
  // supply under-voltage filter times in microseconds (plain defaults)
  localparam int unsigned CORE_UV_SET_US = 10;
  localparam int unsigned CORE_UV_CLR_US = 10;
  localparam int unsigned IO_UV_SET_US = 10;
  localparam int unsigned IO_UV_CLR_US = 10;
  localparam int unsigned CORE_UV_SET_CYC = CORE_UV_SET_US * (CLK_HZ / 1000000);
  localparam int unsigned CORE_UV_CLR_CYC = CORE_UV_CLR_US * (CLK_HZ / 1000000);
  localparam int unsigned IO_UV_SET_CYC = IO_UV_SET_US * (CLK_HZ / 1000000);
  localparam int unsigned IO_UV_CLR_CYC = IO_UV_CLR_US * (CLK_HZ / 1000000);
  // serial status frame
  localparam int unsigned SPI_FRAME_EDGES = 16;
  localparam int unsigned STATUS_W = 16;
  // status word bit positions
  localparam int unsigned ST_BUS_ERR = 0;
  localparam int unsigned ST_THERMAL = 1;
  localparam int unsigned ST_TIMEOUT = 2;
  localparam int unsigned ST_CORE_UV = 3;
  localparam int unsigned ST_IO_UV = 4;
  localparam int unsigned ST_SPI_ERR = 5;
  localparam int unsigned ST_WAKEUP = 6;
  localparam int unsigned ST_NORMAL = 7;
  localparam int unsigned ST_POWER_ON = 8;
  localparam int unsigned ST_TRACK = 9;
  localparam int unsigned ERR_FLAGS = 6;
  // operating modes
  typedef enum logic [0:0] {
    BDMC_STANDBY,
    BDMC_NORMAL
  } bdmc_mode_t;
endpackage

// file: verilog/bdmc_uv_filter.sv
// supply under-voltage detector with separate set and clear filter times
`timescale 1ns/1ps
module bdmc_uv_filter #(
  parameter int unsigned SET_CYC = 400,
  parameter int unsigned CLR_CYC = 400,
  parameter int unsigned CNT_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic below_i,
  output logic uv_o
);
  logic [CNT_W-1:0] cnt_r;
  logic uv_r;
  // counts how long the raw level disagrees with the flag
  wire differ = below_i != uv_r;
  wire [CNT_W-1:0] limit = uv_r ? CNT_W'(CLR_CYC) : CNT_W'(SET_CYC);
  wire done = differ && (cnt_r >= limit - CNT_W'(1));
  // filter state; flag starts set so the supply is proven first
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
      uv_r <= 1'b1;
    end else if (ce_i) begin
      cnt_r <= (differ && !done) ? cnt_r + CNT_W'(1) : '0;
      if (done) begin
        uv_r <= below_i;
      end
    end
  end
  assign uv_o = uv_r;
endmodule

// file: verilog/bdmc_top.sv
// mode, transmitter gating and error indication of the bus driver
`timescale 1ns/1ps
module bdmc_top #(
  parameter int unsigned TX_LIMIT_CYC = bdmc_pkg::TX_ACTIVE_LIMIT_CYC,
  parameter int unsigned CNT_W = 17
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic core_por_ok_i,
  input wire logic core_below_uv_i,
  input wire logic io_below_uv_i,
  input wire logic over_temp_i,
  input wire logic wakeup_detect_i,
  input wire logic standby_select_n_i,
  input wire logic transmit_enable_n_i,
  input wire logic guardian_enable_i,
  input wire logic txd_i,
  input wire logic bus_rx_i,
  input wire logic track_mode_i,
  input wire logic chip_select_n_i,
  input wire logic sck_i,
  input wire logic status_ready_i,
  output logic tx_drive_o,
  output logic tx_data_o,
  output logic rxd_o,
  output logic low_power_o,
  output logic normal_mode_o,
  output logic wakeup_flag_o,
  output logic fault_indicator_n_o,
  output logic serial_status_out_o,
  output logic status_valid_o,
  output logic [bdmc_pkg::STATUS_W-1:0] status_data_o
);
  localparam int unsigned SW = bdmc_pkg::STATUS_W;
  logic core_uv, io_uv;
  logic mode_r, wake_r, pwr_r, therm_r, tmo_r, buserr_r, spierr_r, track_r;
  logic [CNT_W-1:0] tx_cnt_r;
  logic [bdmc_pkg::ERR_FLAGS-1:0] latched_r;
  logic [4:0] edges_r;
  logic [SW-1:0] shift_r;
  logic sel_d_r, sck_d_r;
  logic tx_drive_r, tx_data_r, rxd_r, fault_n_r, ser_out_r;
  // flag outputs kept as flops of their own
  logic low_power_r, valid_r;
  logic [SW-1:0] buf_data_r [2];
  logic [1:0] buf_cnt_r;
  logic buf_rd_r;

  // falling edge against the previous sample
  function automatic logic edge_fall(input logic prev, input logic now);
    return prev && !now;
  endfunction

  // rising edge against the previous sample
  function automatic logic edge_rise(input logic prev, input logic now);
    return !prev && now;
  endfunction

  // supply detectors
  bdmc_uv_filter #(.SET_CYC(bdmc_pkg::CORE_UV_SET_CYC), .CLR_CYC(bdmc_pkg::CORE_UV_CLR_CYC), .CNT_W(16)) u_core (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .below_i(core_below_uv_i || !core_por_ok_i), .uv_o(core_uv));
  bdmc_uv_filter #(.SET_CYC(bdmc_pkg::IO_UV_SET_CYC), .CLR_CYC(bdmc_pkg::IO_UV_CLR_CYC), .CNT_W(16)) u_io (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .below_i(io_below_uv_i), .uv_o(io_uv));

  // mode decision and transmitter qualification
  wire supplies_ok = !core_uv && !io_uv && core_por_ok_i;
  wire want_normal = supplies_ok && standby_select_n_i;
  wire enter_normal = want_normal && !mode_r;
  wire in_normal = mode_r;
  wire wake_set = !mode_r && !core_uv && wakeup_detect_i;
  wire tx_limit_hit = tx_cnt_r >= CNT_W'(TX_LIMIT_CYC - 1);
  wire tx_ready = in_normal && !tmo_r && guardian_enable_i && !therm_r;
  wire tx_on = tx_ready && !transmit_enable_n_i;
  wire bus_mismatch = tx_on && (bus_rx_i != txd_i);

  // serial frame monitor
  wire cs_fall = edge_fall(sel_d_r, chip_select_n_i);
  wire cs_rise = edge_rise(sel_d_r, chip_select_n_i);
  wire sck_fall = edge_fall(sck_d_r, sck_i) && !chip_select_n_i;
  wire frame_bad = (edges_r != 5'(bdmc_pkg::SPI_FRAME_EDGES)) || sck_i;
  wire cs_fall_bad = cs_fall && sck_i;
  wire frame_ok = cs_rise && !frame_bad && !spierr_r;
  wire [bdmc_pkg::ERR_FLAGS-1:0] err_now = {spierr_r, io_uv, core_uv, tmo_r, therm_r, buserr_r};
  wire [SW-1:0] status_word = SW'({track_r, pwr_r, mode_r, wake_r, latched_r | err_now});
  wire error_flag = track_r ? (|err_now) : (|(latched_r | err_now));
  wire buf_push = frame_ok && (buf_cnt_r != 2'(2));
  wire buf_pop = status_valid_o && status_ready_i;
  // fill level after this edge; a push into a full buffer is dropped
  wire [1:0] buf_cnt_nxt = buf_cnt_r + 2'(buf_push) - 2'(buf_pop);

  // mode, wakeup and power-on flags
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r <= 1'b0;
      low_power_r <= 1'b1;
      wake_r <= 1'b0;
      pwr_r <= 1'b0;
    end else if (ce_i) begin
      mode_r <= want_normal;
      low_power_r <= !want_normal;
      // a wakeup seen as Normal is entered survives the clear
      wake_r <= wake_set || (wake_r && !enter_normal);
      pwr_r <= enter_normal ? 1'b0 : (pwr_r || (core_por_ok_i && !pwr_r && !mode_r));
    end
  end

  // thermal, timeout and bus error flags
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      therm_r <= 1'b0;
      tmo_r <= 1'b0;
      tx_cnt_r <= '0;
      buserr_r <= 1'b0;
    end else if (ce_i) begin
      if (!in_normal) begin
        therm_r <= 1'b0;
        tmo_r <= 1'b0;
        tx_cnt_r <= '0;
        buserr_r <= 1'b0;
      end else begin
        therm_r <= over_temp_i || (therm_r && !transmit_enable_n_i);
        tx_cnt_r <= transmit_enable_n_i ? '0 : (tx_limit_hit ? tx_cnt_r : tx_cnt_r + CNT_W'(1));
        tmo_r <= !transmit_enable_n_i && (tmo_r || tx_limit_hit);
        buserr_r <= bus_mismatch || (buserr_r && !tx_on && !transmit_enable_n_i);
      end
    end
  end

  // serial port, error mode and latched status bits
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_d_r <= 1'b1;
      sck_d_r <= 1'b1;
      edges_r <= '0;
      shift_r <= '0;
      spierr_r <= 1'b0;
      track_r <= 1'b0;
      latched_r <= '0;
    end else if (ce_i) begin
      sel_d_r <= chip_select_n_i;
      sck_d_r <= sck_i;
      track_r <= track_mode_i;
      if (cs_fall) begin
        edges_r <= '0;
        shift_r <= status_word;
      end else if (sck_fall) begin
        edges_r <= (edges_r == 5'h1F) ? edges_r : edges_r + 5'h01;
        shift_r <= {shift_r[SW-2:0], 1'b0};
      end
      // set wins over the falling-select clear
      spierr_r <= (cs_rise && frame_bad) || cs_fall_bad || (spierr_r && !cs_fall && !track_mode_i);
      // a clean read clears the sticky bits that are no longer active
      latched_r <= track_r ? '0 : (frame_ok ? err_now : (latched_r | err_now));
    end
  end

  // two-entry buffer of captured status words
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      buf_data_r[0] <= '0;
      buf_data_r[1] <= '0;
      buf_cnt_r <= '0;
      buf_rd_r <= 1'b0;
      valid_r <= 1'b0;
    end else if (ce_i) begin
      if (buf_push) begin
        buf_data_r[buf_rd_r ^ buf_cnt_r[0]] <= status_word;
      end
      if (buf_pop) begin
        buf_rd_r <= !buf_rd_r;
      end
      buf_cnt_r <= buf_cnt_nxt;
      valid_r <= buf_cnt_nxt != 2'(0);
    end
  end

  // registered pin outputs
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_drive_r <= 1'b0;
      tx_data_r <= 1'b0;
      rxd_r <= 1'b1;
      fault_n_r <= 1'b1;
      ser_out_r <= 1'b0;
    end else if (ce_i) begin
      tx_drive_r <= tx_on;
      tx_data_r <= txd_i;
      rxd_r <= in_normal ? bus_rx_i : !(wake_r && !standby_select_n_i);
      fault_n_r <= !((error_flag && standby_select_n_i) || (wake_r && !standby_select_n_i));
      ser_out_r <= chip_select_n_i ? 1'b0 : shift_r[SW-1];
    end
  end

  // outputs straight from their flops; status data through a mux on buf_rd_r
  assign tx_drive_o = tx_drive_r;
  assign tx_data_o = tx_data_r;
  assign rxd_o = rxd_r;
  assign low_power_o = low_power_r;
  assign normal_mode_o = mode_r;
  assign wakeup_flag_o = wake_r;
  assign fault_indicator_n_o = fault_n_r;
  assign serial_status_out_o = ser_out_r;
  assign status_valid_o = valid_r;
  assign status_data_o = buf_data_r[buf_rd_r];
endmodule

// file: testbench/bdmc_host_model.sv
// host side model: serial status reader with a stallable ready
`timescale 1ns/1ps
module bdmc_host_model (
  input wire logic sys_clk_i,
  input wire logic ser_out_i,
  output logic chip_select_n_o,
  output logic sck_o,
  output logic status_ready_o,
  output logic [bdmc_pkg::STATUS_W-1:0] rx_word_o
);
  logic stall = 1'h0;
  // idle: deselected, serial clock parked low
  initial begin
    chip_select_n_o = 1'h1;
    sck_o = 1'h0;
    rx_word_o = '0;
  end
  assign status_ready_o = !stall;
  // one frame of k falling edges, clock low at both select edges
  task automatic frame(input int k);
    @(posedge sys_clk_i) chip_select_n_o <= 1'h0;
    repeat (k) begin
      repeat (3) @(posedge sys_clk_i);
      // take the output bit at the rising serial clock, msb first
      rx_word_o <= {rx_word_o[bdmc_pkg::STATUS_W-2:0], ser_out_i};
      sck_o <= 1'h1;
      repeat (3) @(posedge sys_clk_i);
      sck_o <= 1'h0;
    end
    repeat (3) @(posedge sys_clk_i);
    chip_select_n_o <= 1'h1;
  endtask
endmodule

// file: testbench/bdmc_top_assertions.sv
// concurrent checks on the ports of the bus driver mode control block
`timescale 1ns/1ps
module bdmc_checker (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic over_temp_i,
  input wire logic core_por_ok_i,
  input wire logic standby_select_n_i,
  input wire logic transmit_enable_n_i,
  input wire logic guardian_enable_i,
  input wire logic chip_select_n_i,
  input wire logic status_ready_i,
  input wire logic tx_drive_o,
  input wire logic normal_mode_o,
  input wire logic wakeup_flag_o,
  input wire logic fault_indicator_n_o,
  input wire logic serial_status_out_o,
  input wire logic status_valid_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // transmitter gating
  a_enable_off: assert property (transmit_enable_n_i [*2] |=> !tx_drive_o) else $error("tx on, enable off");
  a_guard_off: assert property (!guardian_enable_i [*2] |=> !tx_drive_o) else $error("tx on, guard low");
  a_standby_idle: assert property (!normal_mode_o && $past(!normal_mode_o) |-> !tx_drive_o)
    else $error("tx on in standby");
  a_heat_off: assert property ((normal_mode_o && over_temp_i) [*3] |=> !tx_drive_o) else $error("tx on, hot");
  // mode selection
  a_select_standby: assert property (ce_i && !standby_select_n_i |=> !normal_mode_o)
    else $error("normal, select low");
  a_por_standby: assert property (ce_i && !core_por_ok_i |=> !normal_mode_o) else $error("normal, no power");
  // pin indications; a low clock enable freezes every flop
  a_fault_quiet: assert property (ce_i && !standby_select_n_i && !wakeup_flag_o |=> fault_indicator_n_o)
    else $error("fault low in standby");
  a_serout_idle: assert property (chip_select_n_i [*3] |=> !serial_status_out_o) else $error("serial out busy");
  // main scenarios
  c_tx: cover property (normal_mode_o && tx_drive_o);
  c_stall: cover property (status_valid_o && !status_ready_i);
  c_fault: cover property (!fault_indicator_n_o);
endmodule
bind bdmc_top bdmc_checker i_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .over_temp_i(over_temp_i),
  .core_por_ok_i(core_por_ok_i), .standby_select_n_i(standby_select_n_i),
  .transmit_enable_n_i(transmit_enable_n_i), .guardian_enable_i(guardian_enable_i),
  .chip_select_n_i(chip_select_n_i), .status_ready_i(status_ready_i), .tx_drive_o(tx_drive_o),
  .normal_mode_o(normal_mode_o), .wakeup_flag_o(wakeup_flag_o), .fault_indicator_n_o(fault_indicator_n_o),
  .serial_status_out_o(serial_status_out_o), .status_valid_o(status_valid_o));

// file: testbench/test_bdmc_top.sv
// self-checking bench of the bus driver mode control block
`timescale 1ns/1ps
module test_bdmc_top;
  localparam int unsigned LIM = 50;
  // expected status words built from the bit positions
  localparam logic [15:0] W_NORMAL = 16'h0001 << bdmc_pkg::ST_NORMAL;
  localparam logic [15:0] W_UV = (16'h0001 << bdmc_pkg::ST_CORE_UV) | (16'h0001 << bdmc_pkg::ST_IO_UV);
  logic sys_clk_i, tx, txdo, rxd, lowp, normal, wflag, fault_n, ser_out, valid;
  logic por_ok = 1'h1, stdby_sel_n = 1'h1, tx_en_n = 1'h1, guard = 1'h1, brx = 1'h1, ce = 1'h1;
  logic nrst_i = 1'h0, uv = 1'h0, heat = 1'h0, wake = 1'h0, txd = 1'h0, track = 1'h0;
  logic [bdmc_pkg::STATUS_W-1:0] sdata, rx_word;
  wire sel_n, sck, rdy;
  int err_total, samples_checked, cycles, n;
  bdmc_top #(.TX_LIMIT_CYC(LIM)) i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce),
    .core_por_ok_i(por_ok), .core_below_uv_i(uv), .io_below_uv_i(uv), .over_temp_i(heat),
    .wakeup_detect_i(wake), .standby_select_n_i(stdby_sel_n), .transmit_enable_n_i(tx_en_n),
    .guardian_enable_i(guard), .txd_i(txd), .bus_rx_i(brx), .track_mode_i(track), .chip_select_n_i(sel_n),
    .sck_i(sck), .status_ready_i(rdy), .tx_drive_o(tx), .tx_data_o(txdo), .rxd_o(rxd), .low_power_o(lowp),
    .normal_mode_o(normal), .wakeup_flag_o(wflag), .fault_indicator_n_o(fault_n),
    .serial_status_out_o(ser_out), .status_valid_o(valid), .status_data_o(sdata));
  bdmc_host_model i_host (.sys_clk_i(sys_clk_i), .ser_out_i(ser_out), .chip_select_n_o(sel_n), .sck_o(sck),
    .status_ready_o(rdy), .rx_word_o(rx_word));
  // compare one value and count it
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // wait k edges, then let outputs settle
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task t_mode;
    cyc(450);
    chk("normal", normal, 1'h1);
    @(posedge sys_clk_i) brx <= 1'h0;
    cyc(3);
    chk("rxd", rxd, 1'h0);
    // a low clock enable freezes the mode against a standby request
    @(posedge sys_clk_i) ce <= 1'h0;
    stdby_sel_n <= 1'h0;
    cyc(3);
    chk("frozen normal", normal, 1'h1);
    @(posedge sys_clk_i) ce <= 1'h1;
    stdby_sel_n <= 1'h1;
    cyc(3);
    chk("normal", normal, 1'h1);
    @(posedge sys_clk_i) stdby_sel_n <= 1'h0;
    cyc(3);
    chk("low_power", lowp, 1'h1);
    chk("rxd", rxd, 1'h1);
    @(posedge sys_clk_i) stdby_sel_n <= 1'h1;
    cyc(3);
    chk("normal", normal, 1'h1);
    $display("mode test done");
  endtask
  task t_spi;
    @(posedge sys_clk_i) i_host.stall <= 1'h1;
    repeat (3) i_host.frame(16);
    cyc(4);
    chk("fault_n", fault_n, 1'h1);
    chk("valid", valid, 1'h1);
    // first word still carries the start-up under-voltage bits, the last read shows them cleared
    chk("status word", sdata, W_NORMAL | W_UV);
    chk("serial word", rx_word, W_NORMAL);
    chk("track bit", sdata[bdmc_pkg::ST_TRACK], 1'h0);
    @(posedge sys_clk_i) i_host.stall <= 1'h0;
    n = 0;
    repeat (8) @(negedge sys_clk_i) if (valid && rdy) n++;
    chk("pops", n[15:0], 16'h0002);
    i_host.frame(15);
    cyc(4);
    chk("fault_n", fault_n, 1'h0);
    @(posedge sys_clk_i) track <= 1'h1;
    cyc(4);
    chk("fault_n", fault_n, 1'h1);
    $display("serial test done");
  endtask
  task t_tx;
    @(posedge sys_clk_i) tx_en_n <= 1'h0;
    @(posedge sys_clk_i) txd <= 1'h1;
    cyc(3);
    chk("tx", tx, 1'h1);
    chk("tx_data", txdo, 1'h1);
    @(posedge sys_clk_i) guard <= 1'h0;
    cyc(3);
    chk("tx", tx, 1'h0);
    @(posedge sys_clk_i) guard <= 1'h1;
    @(posedge sys_clk_i) heat <= 1'h1;
    cyc(3);
    chk("tx", tx, 1'h0);
    @(posedge sys_clk_i) heat <= 1'h0;
    cyc(3);
    chk("tx", tx, 1'h0);
    @(posedge sys_clk_i) tx_en_n <= 1'h1;
    cyc(3);
    chk("tx", tx, 1'h0);
    @(posedge sys_clk_i) tx_en_n <= 1'h0;
    cyc(3);
    chk("tx", tx, 1'h1);
    cyc(LIM);
    chk("tx", tx, 1'h0);
    @(posedge sys_clk_i) tx_en_n <= 1'h1;
    @(posedge sys_clk_i) tx_en_n <= 1'h0;
    cyc(3);
    chk("tx", tx, 1'h1);
    @(posedge sys_clk_i) tx_en_n <= 1'h1;
    $display("transmit test done");
  endtask
  task t_supply;
    @(posedge sys_clk_i) uv <= 1'h1;
    cyc(450);
    chk("normal", normal, 1'h0);
    chk("fault_n", fault_n, 1'h0);
    @(posedge sys_clk_i) uv <= 1'h0;
    cyc(450);
    chk("normal", normal, 1'h1);
    @(posedge sys_clk_i) por_ok <= 1'h0;
    cyc(3);
    chk("normal", normal, 1'h0);
    @(posedge sys_clk_i) por_ok <= 1'h1;
    @(posedge sys_clk_i) stdby_sel_n <= 1'h0;
    @(posedge sys_clk_i) wake <= 1'h1;
    @(posedge sys_clk_i) wake <= 1'h0;
    cyc(3);
    chk("wake flag", wflag, 1'h1);
    chk("rxd", rxd, 1'h0);
    chk("fault_n", fault_n, 1'h0);
    @(posedge sys_clk_i) stdby_sel_n <= 1'h1;
    cyc(3);
    chk("normal", normal, 1'h1);
    $display("supply test done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // clock and hang guard
  initial begin
    sys_clk_i = 1'h0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    forever begin
      @(posedge sys_clk_i) cycles++;
      if (cycles == 30000) begin
        err_total++;
        wrap_up;
      end
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'h1;
    t_mode;
    t_spi;
    t_tx;
    t_supply;
    wrap_up;
  end
endmodule
